/* swd_pkg.sv */
/*
 holds the shared constants of the standby wake source block and the
 per-lane detector that the register front end instantiates once per lane.
 assumes one clock (pclk) and an asynchronous active-low reset.
*/
`timescale 1ns/10ps

package swd_pkg;
   localparam int          ADDR_W        = 12;
   localparam int          DATA_W        = 32;
   localparam int          LANES         = 4;
   localparam int          SEL_W         = 3;
   localparam int          ST_W          = 2;
   localparam int          CLR_W         = 5;
   localparam int          LANE_STRIDE   = 8;
   localparam int          SEL_OFS       = 4;
   localparam int          ST_OFS        = 2;
   localparam int          EN_OFS        = 0;
   localparam logic [ADDR_W-1:0] OFF_MODE_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_CLEAR     = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 12'h00c;
   localparam logic [CLR_W-1:0]  CLR_LVD       = 5'h00;
   localparam logic [CLR_W-1:0]  CLR_PIN0      = 5'h01;
   localparam logic [CLR_W-1:0]  CLR_PIN1      = 5'h02;
   localparam logic [CLR_W-1:0]  CLR_PIN2      = 5'h03;
   localparam logic [ST_W-1:0]   ST_NONE       = 2'h0;
   localparam logic [ST_W-1:0]   ST_RISE       = 2'h1;
   localparam logic [ST_W-1:0]   ST_FALL       = 2'h2;
   localparam logic [LANES-1:0]  RST_MASK      = 4'h0;

   typedef enum logic [SEL_W-1:0] {
      MODE_LOW  = 3'b000,
      MODE_HIGH = 3'b001,
      MODE_FALL = 3'b010,
      MODE_RISE = 3'b011,
      MODE_BOTH = 3'b100
   } swd_mode_t;

   localparam logic [SEL_W-1:0]  RST_SEL       = 3'b010;
endpackage

module swd_lane (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     src_in,
   input  wire logic [swd_pkg::SEL_W-1:0] sel,
   input  wire logic                     enable,
   input  wire logic                     clear,
   output logic                          level,
   output logic                          hit,
   output logic                          pending,
   output logic                          latch_evt,
   output logic [swd_pkg::ST_W-1:0]      edge_st
);
   import swd_pkg::*;

   logic sync1_ff;
   logic sync2_ff;
   logic prev_ff;
   logic pend_ff;
   logic [ST_W-1:0] st_ff;
   logic rise;
   logic fall;
   logic set;

   // pin is asynchronous to pclk: two flops before any logic
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff  <= 1'b0;
      end else begin
         sync1_ff <= src_in;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   assign level = sync2_ff;
   assign rise  = sync2_ff & ~prev_ff;
   assign fall  = ~sync2_ff & prev_ff;

   always_comb begin
      unique case (sel)
         MODE_LOW:  hit = ~sync2_ff;
         MODE_HIGH: hit = sync2_ff;
         MODE_FALL: hit = fall;
         MODE_RISE: hit = rise;
         MODE_BOTH: hit = rise | fall;
         // forbidden codes detect nothing
         default:   hit = 1'b0;
      endcase
   end

   assign set       = enable & hit;
   assign latch_evt = set & ~pend_ff;
   assign pending   = pend_ff;
   assign edge_st   = st_ff;

   // set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_ff <= 1'b0;
      end else if (set) begin
         pend_ff <= 1'b1;
      end else if (clear) begin
         pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_NONE;
      end else if (set && sel == MODE_BOTH) begin
         st_ff <= st_ff | (rise ? ST_RISE : ST_NONE)
                        | (fall ? ST_FALL : ST_NONE);
      end else if (clear) begin
         st_ff <= ST_NONE;
      end
   end
endmodule

/* swd_wake_ctrl.sv */
/*
 standby wake source detect: four wake lanes (low-voltage detector and
 external pins 0..2) with level/edge selection, edge status, enables,
 a request-clear register and a masked read-to-clear interrupt.
 assumes an apb master on pclk and asynchronous pins for the sources.
*/
// Local design decisions: the address map and the APB register port.
// Behaviour
// - selector: 000 low, 001 high, 010 fall, 011 rise, 100 both edges
// - edge status: 01 rising, 10 falling, 11 both, 00 none
// - edge status reads valid only while selector is 100
// - status lets software read back the edges the lane saw while enabled in mode 100 since its request was last cleared
// - clearing a lane request also zeroes that lane's edge status
// - lane enable 0 blocks wake requests, 1 allows them
// - pin 2 lane: selector 30-28, status 27-26, enable 24
// - pin 1 lane: selector 22-20, status 19-18, enable 16
// - pin 0 lane: selector 14-12, status 11-10, enable 8
// - low-voltage lane: selector 6-4, status 3-2, enable 0
// - 5-bit clear code picks one lane's request; others forbidden
`timescale 1ns/10ps

module swd_wake_ctrl (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [swd_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [swd_pkg::DATA_W-1:0]   pwdata,
   output logic      [swd_pkg::DATA_W-1:0]   prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic                         low_voltage_detect_irq,
   input  wire logic                         ext_irq_pin_zero,
   input  wire logic                         ext_irq_pin_one,
   input  wire logic                         ext_irq_pin_two,
   output logic      [swd_pkg::LANES-1:0]    wake_pending,
   output logic                              standby_release,
   output logic                              irq
);
   import swd_pkg::*;

   logic [LANES-1:0]        src;
   logic [SEL_W-1:0]        sel_ff   [LANES];
   logic [LANES-1:0]        en_ff;
   logic [LANES-1:0]        mask_ff;
   logic [LANES-1:0]        stat_ff;
   logic [DATA_W-1:0]       rdata_ff;
   logic [LANES-1:0]        level;
   logic [LANES-1:0]        hit;
   logic [LANES-1:0]        pend;
   logic [LANES-1:0]        evt;
   logic [LANES-1:0]        lane_clr;
   logic [ST_W-1:0]         est      [LANES];
   logic [DATA_W-1:0]       ctrl_word;
   logic [DATA_W-1:0]       nxt_rdata;
   logic                    setup_rd;
   logic                    acc;
   logic                    wr;
   logic                    rd;
   logic                    mapped;

   assign src = {ext_irq_pin_two, ext_irq_pin_one, ext_irq_pin_zero,
                 low_voltage_detect_irq};

   assign acc    = psel & penable;
   assign wr     = acc & pwrite;
   assign rd     = acc & ~pwrite;
   assign setup_rd = psel & ~penable & ~pwrite;
   assign mapped = (paddr == OFF_MODE_CTRL) || (paddr == OFF_CLEAR) ||
                   (paddr == OFF_IRQ_STAT)  || (paddr == OFF_IRQ_MASK);
   // zero wait states: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         // lane g answers clear code g; codes above 3 name no lane here
         assign lane_clr[g] = wr && (paddr == OFF_CLEAR) &&
            (pwdata[CLR_W-1:0] == CLR_W'(g));

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sel_ff[g] <= RST_SEL;
               en_ff[g]  <= 1'b0;
            end else if (wr && paddr == OFF_MODE_CTRL) begin
               sel_ff[g] <= pwdata[g*LANE_STRIDE+SEL_OFS +: SEL_W];
               en_ff[g]  <= pwdata[g*LANE_STRIDE+EN_OFS];
            end
         end

         // status only meaningful in both-edges mode
         always_comb begin
            ctrl_word[g*LANE_STRIDE +: LANE_STRIDE] = '0;
            ctrl_word[g*LANE_STRIDE+SEL_OFS +: SEL_W] = sel_ff[g];
            ctrl_word[g*LANE_STRIDE+EN_OFS] = en_ff[g];
            ctrl_word[g*LANE_STRIDE+ST_OFS +: ST_W] =
               (sel_ff[g] == MODE_BOTH) ? est[g] : ST_NONE;
         end

         // sticky bit; a read clears only what it returned, so an event
         // landing in the setup cycle is kept for the next read
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stat_ff[g] <= 1'b0;
            end else if (evt[g]) begin
               stat_ff[g] <= 1'b1;
            end else if (rd && paddr == OFF_IRQ_STAT && rdata_ff[g]) begin
               stat_ff[g] <= 1'b0;
            end
         end

         swd_lane u_lane (
            .clk       (pclk),
            .rst_n     (presetn),
            .src_in    (src[g]),
            .sel       (sel_ff[g]),
            .enable    (en_ff[g]),
            .clear     (lane_clr[g]),
            .level     (level[g]),
            .hit       (hit[g]),
            .pending   (pend[g]),
            .latch_evt (evt[g]),
            .edge_st   (est[g])
         );
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_ff <= RST_MASK;
      end else if (wr && paddr == OFF_IRQ_MASK) begin
         mask_ff <= pwdata[LANES-1:0];
      end
   end

   // read data captured in setup so prdata comes from a flop
   always_comb begin
      nxt_rdata = '0;
      if (paddr == OFF_MODE_CTRL) begin
         nxt_rdata = ctrl_word;
      end else if (paddr == OFF_IRQ_STAT) begin
         nxt_rdata[LANES-1:0] = stat_ff;
      end else if (paddr == OFF_IRQ_MASK) begin
         nxt_rdata[LANES-1:0] = mask_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff <= '0;
      end else if (setup_rd) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign prdata          = rdata_ff;
   assign wake_pending    = pend;
   assign standby_release = |pend;
   assign irq             = |(stat_ff & mask_ff);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_low_level_wake: assert property (
      en_ff[3] && sel_ff[3] == MODE_LOW && !level[3] |=> pend[3])
      else $error("low level did not latch pin 2 request");

   a_rise_wake: assert property (
      en_ff[0] && sel_ff[0] == MODE_RISE && level[0] && !$past(level[0])
      |=> pend[0])
      else $error("rising edge did not latch lvd request");

   a_disabled_quiet: assert property (
      !en_ff[2] && !pend[2] |=> !pend[2])
      else $error("disabled lane raised a request");

   a_pending_hold: assert property (
      pend[3] && !lane_clr[3] |=> pend[3])
      else $error("pending request dropped without clear");

   a_clear_lane: assert property (
      lane_clr[1] && !(en_ff[1] && hit[1]) |=> !pend[1] && est[1] == ST_NONE)
      else $error("clear left request or edge status");

   a_both_rise_code: assert property (
      en_ff[1] && sel_ff[1] == MODE_BOTH && level[1] && !$past(level[1])
      |=> est[1][0])
      else $error("rising edge not recorded in status");

   a_status_gated: assert property (
      sel_ff[3] != MODE_BOTH |-> ctrl_word[27:26] == 2'b00)
      else $error("edge status visible outside both-edges mode");

   a_pin2_field: assert property (
      wr && paddr == OFF_MODE_CTRL |=>
         sel_ff[3] == $past(pwdata[30:28]) && en_ff[3] == $past(pwdata[24]))
      else $error("pin 2 fields misplaced");

   a_lvd_field: assert property (
      wr && paddr == OFF_MODE_CTRL |=>
         sel_ff[0] == $past(pwdata[6:4]) && en_ff[0] == $past(pwdata[0]))
      else $error("lvd fields misplaced");

   a_reserved_zero: assert property (
      ctrl_word[31] == 1'b0 && ctrl_word[23] == 1'b0 &&
      ctrl_word[15] == 1'b0 && ctrl_word[7] == 1'b0)
      else $error("reserved control bit reads one");

   a_bad_code_ignored: assert property (
      wr && paddr == OFF_CLEAR && pwdata[CLR_W-1:0] > CLR_PIN2
      |-> lane_clr == '0)
      else $error("forbidden clear code cleared a lane");

   a_pin1_field: assert property (
      wr && paddr == OFF_MODE_CTRL |=>
         sel_ff[2] == $past(pwdata[22:20]) && en_ff[2] == $past(pwdata[16]))
      else $error("pin 1 fields misplaced");

   a_pin0_field: assert property (
      wr && paddr == OFF_MODE_CTRL |=>
         sel_ff[1] == $past(pwdata[14:12]) && en_ff[1] == $past(pwdata[8]))
      else $error("pin 0 fields misplaced");

   a_high_level_wake: assert property (
      en_ff[2] && sel_ff[2] == MODE_HIGH && level[2] |=> pend[2])
      else $error("high level did not latch pin 1 request");

   a_fall_wake: assert property (
      en_ff[1] && sel_ff[1] == MODE_FALL && !level[1] && $past(level[1])
      |=> pend[1])
      else $error("falling edge did not latch pin 0 request");

   a_both_fall_code: assert property (
      en_ff[1] && sel_ff[1] == MODE_BOTH && !level[1] && $past(level[1])
      |=> est[1][1])
      else $error("falling edge not recorded in status");

   a_status_visible: assert property (
      sel_ff[1] == MODE_BOTH |-> ctrl_word[11:10] == est[1])
      else $error("edge status hidden in both-edges mode");

   a_status_gate_pin0: assert property (
      sel_ff[1] != MODE_BOTH |-> ctrl_word[11:10] == 2'b00)
      else $error("pin 0 status visible outside both-edges mode");

   a_clear_lvd: assert property (
      wr && paddr == OFF_CLEAR && pwdata[CLR_W-1:0] == CLR_LVD
      |-> lane_clr[0])
      else $error("clear code zero missed the lvd lane");

   a_clear_lvd_lane: assert property (
      lane_clr[0] && !(en_ff[0] && hit[0]) |=> !pend[0] && est[0] == ST_NONE)
      else $error("lvd clear left request or edge status");

   a_stat_sticky: assert property (
      stat_ff[1] && !(rd && paddr == OFF_IRQ_STAT) |=> stat_ff[1])
      else $error("interrupt status dropped without a read");

   a_stat_read_clear: assert property (
      rd && paddr == OFF_IRQ_STAT && rdata_ff[1] && !evt[1] |=> !stat_ff[1])
      else $error("read of interrupt status did not clear it");

   a_event_sets_stat: assert property (
      evt[2] |=> stat_ff[2])
      else $error("wake event did not set interrupt status");

   a_pend_cause: assert property (
      !pend[1] ##1 pend[1] |-> $past(en_ff[1] && hit[1]))
      else $error("pin 0 request rose without an enabled hit");

   a_rdata_hold: assert property (
      !setup_rd |=> $stable(prdata))
      else $error("read data changed outside a read setup");

   a_mask_write: assert property (
      wr && paddr == OFF_IRQ_MASK |=> mask_ff == $past(pwdata[LANES-1:0]))
      else $error("interrupt mask write lost");

   a_mask_readback: assert property (
      setup_rd && paddr == OFF_IRQ_MASK |=>
         prdata[LANES-1:0] == $past(mask_ff))
      else $error("mask read returned a stale value");

   c_lane_wake: cover property (!pend[1] ##1 pend[1]);
   c_both_edges: cover property (est[1] == 2'b11);
   c_fall_wake: cover property (sel_ff[1] == MODE_FALL && !pend[1] ##1 pend[1]);
   c_irq_raise: cover property (!irq ##1 irq);
   c_clear_after_wake: cover property (pend[0] ##[1:20] lane_clr[0]);
endmodule

/* swd_src_model.sv */
/*
 model of the wake sources: low-voltage detector and pins 0..2.
 assumes the bench asks for levels on want; lines follow one pclk later.
*/
`timescale 1ns/10ps

module swd_src_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [3:0] want,
   output logic            lvd,
   output logic            pin0,
   output logic            pin1,
   output logic            pin2
);
   // sources are asynchronous to the block; a cycle of lag is harmless
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {pin2, pin1, pin0, lvd} <= 4'h0;
      end else begin
         {pin2, pin1, pin0, lvd} <= want;
      end
   end
endmodule

/* swd_wake_ctrl_bench.sv */
/*
 self-checking bench for swd_wake_ctrl: apb tasks and source model.
 assumes zero or more wait states; every wait is bounded.
*/
`timescale 1ns/10ps

module swd_wake_ctrl_bench;
   import swd_pkg::*;
   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic [3:0]        want;
   logic              lvd;
   logic              pin0;
   logic              pin1;
   logic              pin2;
   logic [LANES-1:0]  wake_pending;
   logic              standby_release;
   logic              irq;
   logic [DATA_W-1:0] rd;
   logic              err;
   int                errors;
   int                check_count;

   swd_wake_ctrl i_swd_wake_ctrl (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .low_voltage_detect_irq(lvd),
      .ext_irq_pin_zero(pin0), .ext_irq_pin_one(pin1),
      .ext_irq_pin_two(pin2), .wake_pending(wake_pending),
      .standby_release(standby_release), .irq(irq));
   swd_src_model i_swd_src_model (.pclk(pclk), .presetn(presetn),
      .want(want), .lvd(lvd), .pin0(pin0), .pin1(pin1), .pin2(pin2));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic summarize();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t bits %b expected %b", $time, got, exp);
      end
   endtask

   // holds the request until pready is seen high, then releases
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         errors++;
         $display("[ERR] %0t no pready", $time);
         summarize();
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // outputs launched at the access edge settle before callers compare
      @(negedge pclk);
   endtask

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk32(rd, e);
   endtask

   task automatic src(input logic [3:0] v);
      @(posedge pclk);
      want <= v;
      repeat (6) @(posedge pclk);
      @(negedge pclk);
   endtask

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'b000;
      paddr = '0;
      pwdata = '0;
      want = 4'h0;
      errors = 0;
      check_count = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(OFF_MODE_CTRL, 32'h20202020);
      chk4({irq, standby_release, 2'b00}, 4'h0);
      apb(1'b1, OFF_IRQ_MASK, 32'hf);
      // selectors first, enables later; lvd uses rise only
      apb(1'b1, OFF_MODE_CTRL, 32'h20104030);
      rdchk(OFF_MODE_CTRL, 32'h20104030);
      apb(1'b1, OFF_MODE_CTRL, 32'h20104131);
      src(4'h4); // pin1 high while disabled
      chk4(wake_pending, 4'h0);
      src(4'h6);
      src(4'h4);
      chk4(wake_pending, 4'h2);
      chk4({irq, standby_release, 2'b00}, 4'hc);
      rdchk(OFF_MODE_CTRL, 32'h20104d31);
      rdchk(OFF_IRQ_STAT, 32'h2);
      rdchk(OFF_IRQ_STAT, 32'h0);
      chk4({irq, 3'b000}, 4'h0);
      apb(1'b1, OFF_CLEAR, {27'h0, CLR_PIN0});
      chk4(wake_pending, 4'h0);
      rdchk(OFF_MODE_CTRL, 32'h20104131);
      src(4'h5);
      chk4(wake_pending, 4'h1);
      rdchk(OFF_MODE_CTRL, 32'h20104131);
      apb(1'b1, OFF_CLEAR, 32'h5);
      chk4(wake_pending, 4'h1);
      apb(1'b1, OFF_CLEAR, {27'h0, CLR_LVD});
      chk4(wake_pending, 4'h0);
      apb(1'b1, OFF_MODE_CTRL, 32'h20114131);
      repeat (5) @(posedge pclk);
      chk4(wake_pending, 4'h4);
      rdchk(OFF_IRQ_STAT, 32'h5);
      apb(1'b0, 12'h010, 32'h0);
      chk4({err, 3'b000}, 4'h8);
      chk32(rd, 32'h0);
      chk4({pready, 3'b000}, 4'h8);
      // pin2 falls back to low-level mode; pin is low so it latches
      apb(1'b1, OFF_MODE_CTRL, 32'h00114131);
      apb(1'b1, OFF_MODE_CTRL, 32'h01114131);
      repeat (5) @(posedge pclk);
      chk4(wake_pending, 4'hc);
      // pin 0 lane to falling edge, selector before enable
      apb(1'b1, OFF_MODE_CTRL, 32'h01112031);
      apb(1'b1, OFF_MODE_CTRL, 32'h01112131);
      src(4'h6);
      chk4(wake_pending, 4'hc);
      src(4'h4);
      chk4(wake_pending, 4'he);
      rdchk(OFF_MODE_CTRL, 32'h01112131);
      summarize();
   end
endmodule
